// ==== hdl/pinmux_pkg.sv ====
/*
 * Constants for the port B upper pin-function selector: register offsets,
 * field positions, mode encodings and reset values.
 * Assumes a 32-bit APB register bus; offsets are byte addresses.
 */
package pinmux_pkg;
	localparam logic [7:0] FUNC_SELECT_OFFSET = 8'h00;
	localparam logic [7:0] PORT_DATA_OFFSET = 8'h04;
	localparam logic [7:0] PORT_DIR_OFFSET = 8'h08;
	localparam logic [7:0] PORT_LEVEL_OFFSET = 8'h0C;
	localparam int FIELD_PIN8_POS = 0;
	localparam int FIELD_PIN9_POS = 4;
	localparam int FIELD_PIN10_POS = 8;
	localparam int FIELD_PIN11_POS = 12;
	localparam logic [15:0] FIELD_MASK = 16'h3333;
	localparam logic [1:0] MODE_GP = 2'h0;
	localparam logic [1:0] MODE_ADDR = 2'h1;
	localparam logic [1:0] MODE_TIMER = 2'h2;
	localparam logic [1:0] MODE_BAD = 2'h3;
	localparam logic [15:0] FUNC_RESET_BOOT0 = 16'h1111;
	localparam logic [15:0] FUNC_RESET_OTHER = 16'h0000;
	localparam logic [3:0] DATA_RESET = 4'h0;
	localparam logic [3:0] DIR_RESET = 4'h0;
endpackage

// ==== hdl/port_b_upper_pin_function_select.sv ====
/*
 * Pin-function selector for port B pins 8 to 11, with data, direction and
 * live-level registers on APB.
 * Assumes boot_mode_i is stable around reset; pin levels are asynchronous.
 * Assumes the APB master keeps address and data steady through the access
 * phase; the slave never stretches a transfer.
 */
// Behaviour
// - boot mode 0: pin 11 field only accepts 01, address line 11, reset 01
// - boot modes 1-3: pin 11 field 00 port, 01 address, 10 timer B
// - boot mode 0: pin 10 field only accepts 01, address line 10, reset 01
// - boot modes 1-3: pin 10 field 00 port, 01 address, 10 timer A
// - reserved bit pairs read zero; software writes zero
// - port and timer functions take direction from direction register
// - data register, live pin level register, function and direction registers
// - pins 10 and 11 each routed to exactly one function by its field; pins 8 and 9 stay port bits
`timescale 1ns/1ps
module port_b_upper_pin_function_select
	import pinmux_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic [1:0] boot_mode_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [3:0] pin_in_i,
	output logic [3:0] pin_out_o,
	output logic [3:0] pin_oe_o,
	input wire logic [1:0] ext_addr_line_i,
	input wire logic [1:0] timer2_out_i,
	input wire logic [1:0] timer2_oe_i,
	output logic [1:0] timer2_in_o,
	output logic [3:0] pin8_9_mode_o
);
	logic [15:0] port_b_high_function_select;
	logic [3:0] port_data;
	logic [3:0] port_dir;
	logic [3:0] pin_s1;
	logic [3:0] pin_s2;
	logic [3:0] pin_s3;
	logic [3:0] pin_level;
	logic boot0;
	logic wr_en;
	logic hit;
	logic [1:0] pin10_function_field;
	logic [1:0] pin11_function_field;
	logic [3:0] next_pin_out;
	logic [3:0] next_pin_oe;
	logic pin11_code_ok;
	logic pin10_code_ok;

	assign boot0 = (boot_mode_i == 2'h0);
	assign wr_en = psel_i & penable_i & pwrite_i;
	// zero wait: every register answers in the first access cycle
	assign pready_o = 1'b1;
	// unmapped offsets flag an error and change nothing
	assign hit = (paddr_i == FUNC_SELECT_OFFSET) || (paddr_i == PORT_DATA_OFFSET) ||
		(paddr_i == PORT_DIR_OFFSET) || (paddr_i == PORT_LEVEL_OFFSET);
	assign pslverr_o = psel_i & penable_i & ~hit;
	assign pin10_function_field = port_b_high_function_select[FIELD_PIN10_POS +: 2];
	assign pin11_function_field = port_b_high_function_select[FIELD_PIN11_POS +: 2];
	assign pin8_9_mode_o = {port_b_high_function_select[FIELD_PIN9_POS +: 2],
		port_b_high_function_select[FIELD_PIN8_POS +: 2]};

	// boot 1-3: any code but 11 on pin 11
	// boot 0: only the address code on pin 11
	assign pin11_code_ok = (pwdata_i[FIELD_PIN11_POS +: 2] != MODE_BAD) &&
		(!boot0 || pwdata_i[FIELD_PIN11_POS +: 2] == MODE_ADDR);
	// boot 1-3: any code but 11 on pin 10
	// boot 0: only the address code on pin 10
	assign pin10_code_ok = (pwdata_i[FIELD_PIN10_POS +: 2] != MODE_BAD) &&
		(!boot0 || pwdata_i[FIELD_PIN10_POS +: 2] == MODE_ADDR);

	// field update; a prohibited code leaves that field alone
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			port_b_high_function_select <= boot0 ? FUNC_RESET_BOOT0 : FUNC_RESET_OTHER;
		end else if (wr_en && paddr_i == FUNC_SELECT_OFFSET) begin
			// reject prohibited codes
			// reserved pairs are never written, so they stay at their reset zero
			// boot 0 only 01 on pin 11
			if (pin11_code_ok) begin
				port_b_high_function_select[FIELD_PIN11_POS +: 2] <= pwdata_i[FIELD_PIN11_POS +: 2];
			end
			// boot 0 only 01 on pin 10
			if (pin10_code_ok) begin
				port_b_high_function_select[FIELD_PIN10_POS +: 2] <= pwdata_i[FIELD_PIN10_POS +: 2];
			end
			// plain storage fields
			// no encoding known for these, so every code is kept as written
			port_b_high_function_select[FIELD_PIN9_POS +: 2] <= pwdata_i[FIELD_PIN9_POS +: 2];
			port_b_high_function_select[FIELD_PIN8_POS +: 2] <= pwdata_i[FIELD_PIN8_POS +: 2];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			port_data <= DATA_RESET;
		end else if (wr_en && paddr_i == PORT_DATA_OFFSET) begin
			port_data <= pwdata_i[3:0];
		end
	end

	// direction register, 1 drives the pad
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			port_dir <= DIR_RESET;
		end else if (wr_en && paddr_i == PORT_DIR_OFFSET) begin
			port_dir <= pwdata_i[3:0];
		end
	end

	// three stages; level changes when stages two and three agree
	// stage one may go metastable, so only stages two and three are read
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pin_s1 <= 4'h0;
			pin_s2 <= 4'h0;
			pin_s3 <= 4'h0;
			pin_level <= 4'h0;
		end else begin
			pin_s1 <= pin_in_i;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_level <= (pin_s2 & pin_s3) | (pin_level & (pin_s2 | pin_s3));
		end
	end

	// read data registered; answer on the access cycle of a zero-wait transfer
	// loaded in setup so the output is a flop, at the cost of a setup-time read
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			if (paddr_i == FUNC_SELECT_OFFSET) begin
				prdata_o <= {16'h0000, port_b_high_function_select & FIELD_MASK};
			end else if (paddr_i == PORT_DATA_OFFSET) begin
				prdata_o <= {28'h0000000, port_data};
			end else if (paddr_i == PORT_DIR_OFFSET) begin
				prdata_o <= {28'h0000000, port_dir};
			end else if (paddr_i == PORT_LEVEL_OFFSET) begin
				prdata_o <= {28'h0000000, pin_level};
			end else begin
				prdata_o <= 32'h0000_0000;
			end
		end
	end

	always_comb begin
		next_pin_out = port_data;
		next_pin_oe = port_dir;
		// pin 10 function by its field
		case (pin10_function_field)
			MODE_ADDR: begin
				// address lines drive regardless of what the direction register says
				next_pin_out[2] = ext_addr_line_i[0];
				next_pin_oe[2] = 1'b1;
			end
			MODE_TIMER: begin
				next_pin_out[2] = timer2_out_i[0];
				next_pin_oe[2] = port_dir[2] & timer2_oe_i[0];
			end
			default: begin
				next_pin_out[2] = port_data[2];
				next_pin_oe[2] = port_dir[2];
			end
		endcase
		// pin 11 function by its field
		case (pin11_function_field)
			MODE_ADDR: begin
				// address lines drive regardless of what the direction register says
				next_pin_out[3] = ext_addr_line_i[1];
				next_pin_oe[3] = 1'b1;
			end
			MODE_TIMER: begin
				next_pin_out[3] = timer2_out_i[1];
				next_pin_oe[3] = port_dir[3] & timer2_oe_i[1];
			end
			default: begin
				next_pin_out[3] = port_data[3];
				next_pin_oe[3] = port_dir[3];
			end
		endcase
	end

	// pins 8 and 9 functions undefined here: kept as port bits
	// pads released during reset; address pins drive one edge after it
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pin_out_o <= 4'h0;
			pin_oe_o <= 4'h0;
		end else begin
			pin_out_o <= next_pin_out;
			pin_oe_o <= next_pin_oe;
		end
	end

	// timer sees the pin only in timer mode
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			timer2_in_o <= 2'h0;
		end else begin
			timer2_in_o[0] <= (pin10_function_field == MODE_TIMER) & pin_level[2];
			timer2_in_o[1] <= (pin11_function_field == MODE_TIMER) & pin_level[3];
		end
	end
endmodule

// ==== verif/pinmux_assertions.sv ====
/* Port checks on the pin selector top.
 * Bound from tb; single clock, sync reset. */
`timescale 1ns/1ps
module pinmux_chk(
	input wire logic clk_sys_i, rst_i, psel_i, penable_i, pwrite_i, pslverr_o,
	input wire logic [1:0] boot_mode_i, ext_addr_line_i, timer2_in_o,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i, prdata_o,
	input wire logic [3:0] pin_out_o, pin_oe_o, pin8_9_mode_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	logic acc, r0, w0;
	assign acc = psel_i && penable_i;
	assign r0 = acc && !pwrite_i && paddr_i == 8'h00;
	assign w0 = acc && pwrite_i && paddr_i == 8'h00;
	property p_res; r0 |-> (prdata_o & 32'hFFFFCCCC) == 32'h0; endproperty
	a_res: assert property (p_res) else $error("reserved bits read set");
	property p_boot0; boot_mode_i == 2'h0 && r0 |-> prdata_o[13:12] == 2'h1 && prdata_o[9:8] == 2'h1; endproperty
	a_boot0: assert property (p_boot0) else $error("pin10/11 field left 01");
	property p_bad; w0 && pwdata_i[13:12] == 2'h3 |=> ##1 $stable(pin_oe_o[3]); endproperty
	a_bad: assert property (p_bad) else $error("code 11 taken");
	property p_wr89; w0 && pwdata_i[1:0] != 2'h3 |=> pin8_9_mode_o[1:0] == $past(pwdata_i[1:0]); endproperty
	a_wr89: assert property (p_wr89) else $error("pin8 field not stored");
	property p_addr; boot_mode_i == 2'h0 |=> pin_oe_o[3:2] == 2'h3 && pin_out_o[3:2] == $past(ext_addr_line_i); endproperty
	a_addr: assert property (p_addr) else $error("address pins not driven");
	property p_tin; boot_mode_i == 2'h0 |-> timer2_in_o == 2'h0; endproperty
	a_tin: assert property (p_tin) else $error("timer input leaks");
	property p_err; acc && paddr_i > 8'h0C |-> pslverr_o; endproperty
	a_err: assert property (p_err) else $error("unmapped not flagged");
	property p_hold; !(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
endmodule

// ==== verif/tb.sv ====
/* Self-checking bench: APB tasks, two boot modes.
 * Assumes the selector answers with pready. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb import pinmux_pkg::*;;
	logic clk_sys_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
	logic [1:0] boot_mode_i = 2'h1, ext_addr_line_i = 2'h1, timer2_out_i = 2'h2, timer2_oe_i = 2'h3, timer2_in_o;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o;
	logic [3:0] pin_in_i = 4'hA, pin_out_o, pin_oe_o, pin8_9_mode_o;
	int fail_count = 0, cmp_count = 0;
	port_b_upper_pin_function_select i_port_b_upper_pin_function_select(.*);
	always #50 clk_sys_i = ~clk_sys_i;
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		paddr_i <= a;
		pwrite_i <= w;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_sys_i);
			if (++n > 20) begin
				fail_count++;
				close_out();
			end
		end while (pready_o !== 1'b1);
		q = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(a, 1'b1, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		apb(a, 1'b0, 32'h0, q);
		`CHK("prdata", e, q)
	endtask
	task automatic init(input logic [1:0] b);
		rst_i <= 1'b1;
		boot_mode_i <= b;
		repeat (10) @(posedge clk_sys_i);
		rst_i <= 1'b0;
	endtask
	initial begin
		init(2'h1);
		rd(FUNC_SELECT_OFFSET, 32'h0);
		wr(FUNC_SELECT_OFFSET, 32'h3333);
		rd(FUNC_SELECT_OFFSET, 32'h33);
		wr(FUNC_SELECT_OFFSET, 32'h2221);
		wr(PORT_DIR_OFFSET, 32'h8);
		rd(FUNC_SELECT_OFFSET, 32'h2221);
		// level sync takes a few edges
		repeat (5) @(posedge clk_sys_i);
		`CHK("oe", 4'h8, pin_oe_o)
		`CHK("out3", 1'b1, pin_out_o[3])
		`CHK("tin", 2'h2, timer2_in_o)
		wr(FUNC_SELECT_OFFSET, 32'h3103);
		rd(FUNC_SELECT_OFFSET, 32'h2103);
		repeat (2) @(posedge clk_sys_i);
		`CHK("addr10", 2'h3, {pin_oe_o[2], pin_out_o[2]})
		wr(FUNC_SELECT_OFFSET, 32'h0);
		wr(PORT_DATA_OFFSET, 32'h5);
		wr(PORT_DIR_OFFSET, 32'hC);
		repeat (2) @(posedge clk_sys_i);
		`CHK("gp", 4'h4, pin_out_o & pin_oe_o)
		rd(PORT_LEVEL_OFFSET, 32'hA);
		rd(PORT_DATA_OFFSET, 32'h5);
		rd(8'h10, 32'h0);
		$display("test boot1 done");
		init(2'h0);
		rd(FUNC_SELECT_OFFSET, 32'h1111);
		wr(FUNC_SELECT_OFFSET, 32'h0022);
		rd(FUNC_SELECT_OFFSET, 32'h1122);
		$display("test boot0 done");
		close_out();
	end
endmodule
bind port_b_upper_pin_function_select pinmux_chk i_pinmux_chk(.*);
